// >>> hw/charger_params.svh
// register offsets, field positions, reset values and limits of the option and current bank
`ifndef CHARGER_PARAMS_SVH
`define CHARGER_PARAMS_SVH

// ----------------------------------------
// command codes (register offsets)
// ----------------------------------------
`define CMD_OPTION0 8'h12
`define CMD_CURRENT 8'h14
`define CMD_STATUS 8'h21

// ----------------------------------------
// option register fields
// ----------------------------------------
`define OPT_RESET 16'hE70E
`define OPT_CMP_LATCH 7
`define OPT_UVP_DIS 6
`define OPT_GAUGE_CAL 5
`define OPT_IN_GAIN 4
`define OPT_BAT_GAIN 3
`define OPT_LIN_PRE 2
`define OPT_IN_REG 1
`define OPT_CHG_BLOCK 0
`define OPT_AUTO_IN_OFF 12

// ----------------------------------------
// charge current register fields and status flag bit
// ----------------------------------------
`define CUR_RESET 16'h0000
`define CUR_VALID_MASK 16'h1FC0
`define CUR_RSVD_HI 15:13
`define CUR_FIELD 12:6
`define STATUS_CMP_BIT 6

// ----------------------------------------
// precharge clamps in mA
// ----------------------------------------
`define CLAMP_LOW_MA 13'h0180
`define CLAMP_HIGH_MA 13'h07D0

`endif

// >>> hw/charger_pkg.sv
// types shared by the charger register bank
package charger_pkg;
	typedef enum logic [4:0] {
		st_idle = 5'b00001,
		st_rx = 5'b00010,
		st_ack = 5'b00100,
		st_tx = 5'b01000,
		st_mack = 5'b10000
	} bus_state_e;
	typedef logic [15:0] word_t;
	typedef logic [12:0] milliamp_t;
endpackage

// >>> hw/sync2.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] meta_q;

	// all inputs idle high, so reset to ones to avoid false edges
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '1;
			pin_sync <= '1;
		end else begin
			meta_q <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule

// >>> hw/charger_option_and_current_regs.sv
// option and charge current register bank behind an smbus word slave
`timescale 1ns/1ps
`include "charger_params.svh"
// How it works
// - with latch enabled, comparator output pin stays low once tripped low.
// - comparator status flag set on trip (profile enabled), cleared by host read.
// - toggling latch enable bit releases the latched comparator output pin.
// - undervoltage protection active while disable bit is zero (reset zero).
// - gauge calibration bit set: battery discharges, converter off; host clears it.
// - input amplifier gain twenty when bit zero (default), forty when one.
// - battery amplifier gain eight when zero, sixteen when one (default).
// - linear precharge below min system: current from setting, clamped 384 mA or 2 A.
// - linear precharge off: battery switch fully on, regulate from max voltage.
// - regulation enable reads zero after auto disable; resets to one; host may reset.
// - charge block zero starts charging with valid settings; one inhibits charging.
// - charge current spans zero to 8.128 A in 64 mA steps.
// - current forced to zero on reset, removal, adapter loss, reset cmd, zero volt, watchdog.
// - current kept unchanged on latch-off and protection faults.
// - bits 12..8 weigh 4096, 2048, 1024, 512, 256 mA, summed.
// - write with any of top three bits set is invalid and ignored.
// - bits 7 and 6 weigh 128 and 64 mA; low six bits ignored.
module charger_option_and_current_regs
	import charger_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// smbus pins, open drain
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// analog status pins
	input wire logic comparator_in,
	input wire logic cell_count_battery_present,
	input wire logic adapter_valid_status,
	// charger core status, same clock
	input wire logic battery_below_min_sys,
	input wire logic single_cell,
	input wire logic vbat_above_3v0,
	input wire logic throttle_profile_enable,
	input wire logic charge_voltage_valid,
	// clearing events, one-cycle pulses
	input wire logic register_reset_cmd,
	input wire logic charge_voltage_zero_write,
	input wire logic watchdog_expired,
	// controls to the analog loops
	output logic comparator_output_pin,
	output logic comparator_status,
	output logic sys_uvp_active,
	output logic gauge_calibration_discharge_enable,
	output logic input_gain_40,
	output logic battery_gain_16,
	output logic battery_switch_full_on,
	output logic sys_reg_from_max_voltage,
	output logic input_regulation_active,
	output logic charge_enable,
	output milliamp_t charge_current_ma,
	output milliamp_t precharge_current_ma
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic scl_s, sda_s, comp_s, batpres_s, acok_s;
	sync2 #(.WIDTH(5)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.pin_in({scl, sda_in, comparator_in, cell_count_battery_present, adapter_valid_status}),
		.pin_sync({scl_s, sda_s, comp_s, batpres_s, acok_s})
	);
	logic scl_p_q, sda_p_q, comp_p_q, batpres_p_q, start, stop, scl_rise, scl_fall;
	assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	// ----------------------------------------
	// smbus word engine
	// ----------------------------------------
	bus_state_e st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sr_q, sr_d, cmd_q, cmd_d, lo_q, lo_d, tx_q, tx_d;
	logic [1:0] byte_q, byte_d;
	logic rw_q, rw_d, full_q, full_d, hi_q, hi_d, mack_q, mack_d, oe_q, oe_d;
	logic wr_go, rd_go, latch_q, latch_d, flag_q, flag_d;
	word_t wr_word, rd_word, opt_q, opt_d, cur_q, cur_d;
	assign wr_word = {sr_q, lo_q};
	// read data is the live register content, auto-cleared bits included
	always_comb begin
		case (cmd_q)
			`CMD_OPTION0: rd_word = opt_q;
			`CMD_CURRENT: rd_word = cur_q;
			`CMD_STATUS: rd_word = 16'(flag_q) << `STATUS_CMP_BIT;
			default: rd_word = 16'h0000;
		endcase
	end
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sr_d = sr_q;
		byte_d = byte_q;
		rw_d = rw_q;
		full_d = full_q;
		cmd_d = cmd_q;
		lo_d = lo_q;
		tx_d = tx_q;
		hi_d = hi_q;
		mack_d = mack_q;
		oe_d = oe_q;
		wr_go = 1'b0;
		rd_go = 1'b0;
		if (start) begin
			st_d = st_rx;
			cnt_d = 3'h0;
			byte_d = 2'h0;
			full_d = 1'b0;
			hi_d = 1'b0;
			oe_d = 1'b0;
		end else if (stop) begin
			st_d = st_idle;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				st_rx: begin
					if (scl_rise) begin
						sr_d = {sr_q[6:0], sda_s};
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == 3'h7) begin
							full_d = 1'b1;
						end
					end else if (scl_fall && full_q) begin
						full_d = 1'b0;
						st_d = st_ack;
						oe_d = 1'b1;
						if (byte_q != 2'h3) begin
							byte_d = byte_q + 2'h1;
						end
						case (byte_q)
							2'h0: begin
								rw_d = sr_q[0];
								if (sr_q[7:1] != DEV_ADDR) begin
									st_d = st_idle;
									oe_d = 1'b0;
								end
							end
							2'h1: cmd_d = sr_q;
							2'h2: lo_d = sr_q;
							default: begin
								// only one word per transfer; extra bytes get a nack
								hi_d = 1'b1;
								if (!hi_q) begin
									wr_go = 1'b1;
								end else begin
									st_d = st_idle;
									oe_d = 1'b0;
								end
							end
						endcase
					end
				end
				st_ack: begin
					if (scl_fall) begin
						cnt_d = 3'h0;
						if (rw_q) begin
							st_d = st_tx;
							tx_d = rd_word[7:0];
							lo_d = rd_word[15:8];
							hi_d = 1'b0;
							rd_go = 1'b1;
							oe_d = ~rd_word[7];
						end else begin
							st_d = st_rx;
							oe_d = 1'b0;
						end
					end
				end
				st_tx: begin
					if (scl_fall) begin
						if (cnt_q == 3'h7) begin
							st_d = st_mack;
							oe_d = 1'b0;
						end else begin
							tx_d = {tx_q[6:0], 1'b0};
							cnt_d = cnt_q + 3'h1;
							oe_d = ~tx_q[6];
						end
					end
				end
				st_mack: begin
					if (scl_rise) begin
						mack_d = ~sda_s;
					end else if (scl_fall) begin
						if (mack_q && !hi_q) begin
							st_d = st_tx;
							tx_d = lo_q;
							hi_d = 1'b1;
							cnt_d = 3'h0;
							oe_d = ~lo_q[7];
						end else begin
							st_d = st_idle;
						end
					end
				end
				default: st_d = st_idle;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= st_idle;
			cnt_q <= 3'h0;
			sr_q <= 8'h00;
			byte_q <= 2'h0;
			rw_q <= 1'b0;
			full_q <= 1'b0;
			cmd_q <= 8'h00;
			lo_q <= 8'h00;
			tx_q <= 8'h00;
			hi_q <= 1'b0;
			mack_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sr_q <= sr_d;
			byte_q <= byte_d;
			rw_q <= rw_d;
			full_q <= full_d;
			cmd_q <= cmd_d;
			lo_q <= lo_d;
			tx_q <= tx_d;
			hi_q <= hi_d;
			mack_q <= mack_d;
			oe_q <= oe_d;
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = oe_q;
	// ----------------------------------------
	// register bank and controls
	// ----------------------------------------
	logic batpres_fall, cmp_trip, cur_clear, latch_toggle, cmp_pin_d, cal_d, chg_d;
	milliamp_t cur_ma, clamp_ma, pre_d;
	assign batpres_fall = batpres_p_q & ~batpres_s;
	assign cmp_trip = comp_p_q & ~comp_s & throttle_profile_enable;
	// faults such as latch-off or protection trips are not clear sources here
	assign cur_clear = batpres_fall | ~acok_s | register_reset_cmd |
		charge_voltage_zero_write | watchdog_expired;
	assign latch_toggle = wr_go && (cmd_q == `CMD_OPTION0) &&
		(wr_word[`OPT_CMP_LATCH] != opt_q[`OPT_CMP_LATCH]);
	assign cur_ma = {cur_q[`CUR_FIELD], 6'h00};
	assign sys_uvp_active = ~opt_q[`OPT_UVP_DIS];
	assign input_gain_40 = opt_q[`OPT_IN_GAIN];
	assign battery_gain_16 = opt_q[`OPT_BAT_GAIN];
	assign battery_switch_full_on = ~opt_q[`OPT_LIN_PRE];
	assign sys_reg_from_max_voltage = ~opt_q[`OPT_LIN_PRE];
	assign input_regulation_active = opt_q[`OPT_IN_REG];
	assign comparator_status = flag_q;
	always_comb begin
		opt_d = opt_q;
		cur_d = cur_q;
		latch_d = latch_q;
		flag_d = flag_q;
		if (wr_go && cmd_q == `CMD_OPTION0) begin
			opt_d = wr_word;
		end
		if (wr_go && cmd_q == `CMD_CURRENT && wr_word[`CUR_RSVD_HI] == 3'h0) begin
			cur_d = wr_word & `CUR_VALID_MASK;
		end
		if (register_reset_cmd) begin
			opt_d = `OPT_RESET;
		end
		// hardware disable wins over a host write in the same cycle
		if (opt_q[`OPT_AUTO_IN_OFF] && batpres_fall) begin
			opt_d[`OPT_IN_REG] = 1'b0;
		end
		if (cur_clear) begin
			cur_d = `CUR_RESET;
		end
		if (latch_toggle || !opt_q[`OPT_CMP_LATCH]) begin
			latch_d = 1'b0;
		end else if (!comp_s) begin
			latch_d = 1'b1;
		end
		if (rd_go && cmd_q == `CMD_STATUS) begin
			flag_d = 1'b0;
		end
		if (cmp_trip) begin
			flag_d = 1'b1;
		end
	end
	always_comb begin
		cmp_pin_d = opt_q[`OPT_CMP_LATCH] ? (comp_s & ~latch_q) : comp_s;
		cal_d = opt_q[`OPT_GAUGE_CAL];
		// a calibration discharge also stops charging
		chg_d = ~opt_q[`OPT_CHG_BLOCK] & ~opt_q[`OPT_GAUGE_CAL] & charge_voltage_valid &
			(cur_q[`CUR_FIELD] != 7'h00);
		clamp_ma = (single_cell && vbat_above_3v0) ? `CLAMP_HIGH_MA : `CLAMP_LOW_MA;
		pre_d = cur_ma;
		if (opt_q[`OPT_LIN_PRE] && battery_below_min_sys && cur_ma > clamp_ma) begin
			pre_d = clamp_ma;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			comp_p_q <= 1'b1;
			batpres_p_q <= 1'b1;
			opt_q <= `OPT_RESET;
			cur_q <= `CUR_RESET;
			latch_q <= 1'b0;
			flag_q <= 1'b0;
			comparator_output_pin <= 1'b1;
			gauge_calibration_discharge_enable <= 1'b0;
			charge_enable <= 1'b0;
			charge_current_ma <= 13'h0000;
			precharge_current_ma <= 13'h0000;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			comp_p_q <= comp_s;
			batpres_p_q <= batpres_s;
			opt_q <= opt_d;
			cur_q <= cur_d;
			latch_q <= latch_d;
			flag_q <= flag_d;
			comparator_output_pin <= cmp_pin_d;
			gauge_calibration_discharge_enable <= cal_d;
			charge_enable <= chg_d;
			charge_current_ma <= cur_ma;
			precharge_current_ma <= pre_d;
		end
	end
endmodule

// >>> dv/smbus_host_model.sv
// smbus host that drives word reads and writes into the bank
`timescale 1ns/1ps
module smbus_host_model
	import charger_pkg::*;
#(
	parameter logic [6:0] ADDR = 7'h2A // arbitrary bus address
) (
	// clock
	input wire logic clk,
	// bus
	input wire logic sda,
	output logic scl,
	output logic sda_o
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	// long phases keep well clear of the two-flop sync delay
	task automatic hp();
		repeat (8) @(negedge clk);
	endtask
	task automatic sbit(input logic b, output logic q);
		sda_o = b;
		hp();
		scl = 1'b1;
		hp();
		q = sda;
		scl = 1'b0;
	endtask
	task automatic bx(input logic [7:0] d, input logic m, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			sbit(d[i], q[i]);
		end
		sbit(m, a);
	endtask
	task automatic start();
		sda_o = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_o = 1'b0;
		hp();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_o = 1'b1;
		hp();
	endtask
	task automatic wr(input logic [7:0] c, input word_t v);
		logic [7:0] q;
		start();
		bx({ADDR, 1'b0}, 1'b1, q);
		bx(c, 1'b1, q);
		bx(v[7:0], 1'b1, q);
		bx(v[15:8], 1'b1, q);
		stop();
	endtask
	task automatic rd(input logic [7:0] c, output word_t v);
		logic [7:0] q;
		start();
		bx({ADDR, 1'b0}, 1'b1, q);
		bx(c, 1'b1, q);
		start();
		bx({ADDR, 1'b1}, 1'b1, q);
		bx(8'hFF, 1'b0, v[7:0]);
		bx(8'hFF, 1'b1, v[15:8]);
		stop();
	endtask
endmodule

// >>> dv/charger_option_and_current_regs_assertions.sv
// port-level checker for the option and current bank
`timescale 1ns/1ps
`include "charger_params.svh"
module charger_regs_checker
	import charger_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// inputs
	input wire logic comparator_in,
	input wire logic cell_count_battery_present,
	input wire logic adapter_valid_status,
	input wire logic throttle_profile_enable,
	input wire logic register_reset_cmd,
	input wire logic charge_voltage_zero_write,
	input wire logic watchdog_expired,
	// outputs
	input wire logic comparator_output_pin,
	input wire logic comparator_status,
	input wire logic gauge_calibration_discharge_enable,
	input wire logic battery_gain_16,
	input wire logic battery_switch_full_on,
	input wire logic sys_reg_from_max_voltage,
	input wire logic input_regulation_active,
	input wire logic charge_enable,
	input wire milliamp_t charge_current_ma,
	input wire milliamp_t precharge_current_ma
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// pin events pass the synchroniser, so allow a few cycles
	sequence cur_gone_s;
		##[1:6] charge_current_ma == 13'h0;
	endsequence
	wdog_clear_a: assert property (watchdog_expired |-> ##2 charge_current_ma == 13'h0)
		else $error("watchdog left current");
	vzero_clear_a: assert property (charge_voltage_zero_write |-> ##2 charge_current_ma == 13'h0)
		else $error("zero voltage left current");
	rcmd_clear_a: assert property (register_reset_cmd |-> ##2 (charge_current_ma == 13'h0
		&& battery_gain_16 && input_regulation_active)) else $error("reset command missed");
	removal_clear_a: assert property ($fell(cell_count_battery_present) |-> cur_gone_s)
		else $error("removal left current");
	adapter_clear_a: assert property (!adapter_valid_status [*8] |-> charge_current_ma == 13'h0)
		else $error("adapter loss left current");
	step_grid_a: assert property (charge_current_ma[5:0] == 6'h0 && charge_current_ma <= 13'h1FC0)
		else $error("current off grid");
	clamp_set_a: assert property (precharge_current_ma == charge_current_ma
		|| precharge_current_ma == `CLAMP_LOW_MA || precharge_current_ma == `CLAMP_HIGH_MA)
		else $error("bad precharge value");
	enable_gate_a: assert property (charge_enable |-> charge_current_ma != 13'h0
		&& !gauge_calibration_discharge_enable) else $error("charge enabled wrongly");
	switch_pair_a: assert property (battery_switch_full_on == sys_reg_from_max_voltage)
		else $error("switch and regulation split");
	cmp_fall_a: assert property ($fell(comparator_output_pin) |-> (!$past(comparator_in, 2)
		|| !$past(comparator_in, 3) || !$past(comparator_in, 4))) else $error("pin fell untripped");
	stat_rise_a: assert property ($rose(comparator_status) |-> ($past(throttle_profile_enable)
		|| $past(throttle_profile_enable, 2))) else $error("flag set without profile");
endmodule
bind charger_option_and_current_regs charger_regs_checker chk (.clk, .rstn, .comparator_in,
	.cell_count_battery_present, .adapter_valid_status, .throttle_profile_enable,
	.register_reset_cmd, .charge_voltage_zero_write, .watchdog_expired, .comparator_output_pin,
	.comparator_status, .gauge_calibration_discharge_enable, .battery_gain_16,
	.battery_switch_full_on, .sys_reg_from_max_voltage, .input_regulation_active,
	.charge_enable, .charge_current_ma, .precharge_current_ma);

// >>> dv/charger_option_and_current_regs_tb.sv
// self-checking bench for the option and charge current bank
`timescale 1ns/1ps
`include "charger_params.svh"
module charger_option_and_current_regs_tb;
	import charger_pkg::*;
	logic clk, rstn, scl, sda, host_sda, sda_out, sda_oe, comparator_in, cell_count_battery_present;
	logic adapter_valid_status, battery_below_min_sys, single_cell, vbat_above_3v0;
	logic throttle_profile_enable, charge_voltage_valid, register_reset_cmd;
	logic charge_voltage_zero_write, watchdog_expired, comparator_output_pin, comparator_status;
	logic sys_uvp_active, gauge_calibration_discharge_enable, input_gain_40, battery_gain_16;
	logic battery_switch_full_on, sys_reg_from_max_voltage, input_regulation_active, charge_enable;
	milliamp_t charge_current_ma, precharge_current_ma;
	word_t r;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	// open drain with pull-up: released line reads high
	assign sda = host_sda & ~(sda_oe & ~sda_out);
	charger_option_and_current_regs uut (.clk, .rstn, .scl, .sda_in(sda), .sda_out, .sda_oe,
		.comparator_in, .cell_count_battery_present, .adapter_valid_status,
		.battery_below_min_sys, .single_cell, .vbat_above_3v0, .throttle_profile_enable,
		.charge_voltage_valid, .register_reset_cmd, .charge_voltage_zero_write,
		.watchdog_expired, .comparator_output_pin, .comparator_status, .sys_uvp_active,
		.gauge_calibration_discharge_enable, .input_gain_40, .battery_gain_16,
		.battery_switch_full_on, .sys_reg_from_max_voltage, .input_regulation_active,
		.charge_enable, .charge_current_ma, .precharge_current_ma);
	smbus_host_model host (.clk, .sda, .scl, .sda_o(host_sda));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt = error_cnt + 1;
			complete_run();
		end
	end
	task automatic cw(input word_t got, input word_t exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t word %h want %h", $time, got, exp);
		end
	endtask
	task automatic cb(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t bit %b want %b", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic opt_chk(input word_t v, input logic c);
		host.wr(`CMD_OPTION0, v);
		host.rd(`CMD_OPTION0, r);
		cw(r, v);
		cb(sys_uvp_active, ~v[6]);
		cb(gauge_calibration_discharge_enable, v[5]);
		cb(input_gain_40, v[4]);
		cb(battery_gain_16, v[3]);
		cb(battery_switch_full_on, ~v[2]);
		cb(sys_reg_from_max_voltage, ~v[2]);
		cb(input_regulation_active, v[1]);
		cb(charge_enable, ~v[0] & ~v[5] & c);
	endtask
	task automatic cur_chk(input word_t v, input word_t exp);
		host.wr(`CMD_CURRENT, v);
		cw({3'h0, charge_current_ma}, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	initial begin
		{rstn, comparator_in, cell_count_battery_present, adapter_valid_status} = 4'h7;
		{battery_below_min_sys, single_cell, vbat_above_3v0, throttle_profile_enable} = 4'h0;
		{charge_voltage_valid, register_reset_cmd, charge_voltage_zero_write} = 3'h4;
		watchdog_expired = 1'b0;
		wt(8);
		rstn = 1'b1;
		wt(4);
		host.rd(`CMD_OPTION0, r);
		cw(r, 16'hE70E);
		host.rd(`CMD_CURRENT, r);
		cw(r, 16'h0000);
		host.rd(8'h13, r);
		cw(r, 16'h0000);
		cur_chk(16'h0555, 16'h0540);
		cur_chk(16'hE040, 16'h0540);
		cur_chk(16'h1FC0, 16'h1FC0);
		opt_chk(16'hE77D, 1'b1);
		opt_chk(16'hE702, 1'b1);
		battery_below_min_sys = 1'b1;
		wt(4);
		cw({3'h0, precharge_current_ma}, 16'h1FC0);
		opt_chk(16'hE70E, 1'b1);
		cw({3'h0, precharge_current_ma}, {3'h0, `CLAMP_LOW_MA});
		single_cell = 1'b1;
		vbat_above_3v0 = 1'b1;
		wt(4);
		cw({3'h0, precharge_current_ma}, {3'h0, `CLAMP_HIGH_MA});
		// latched trip, status flag, then release by toggling the latch bit
		throttle_profile_enable = 1'b1;
		opt_chk(16'hE78E, 1'b1);
		comparator_in = 1'b0;
		wt(10);
		comparator_in = 1'b1;
		wt(10);
		cb(comparator_output_pin, 1'b0);
		cb(comparator_status, 1'b1);
		host.rd(`CMD_STATUS, r);
		cb(r[`STATUS_CMP_BIT], 1'b1);
		host.rd(`CMD_STATUS, r);
		cb(r[`STATUS_CMP_BIT], 1'b0);
		cb(comparator_status, 1'b0);
		host.wr(`CMD_OPTION0, 16'hE70E);
		cb(comparator_output_pin, 1'b1);
		comparator_in = 1'b0;
		wt(10);
		cb(comparator_output_pin, 1'b0);
		comparator_in = 1'b1;
		wt(10);
		cb(comparator_output_pin, 1'b1);
		for (int k = 0; k < 5; k++) begin
			cur_chk(16'h0040, 16'h0040);
			{register_reset_cmd, charge_voltage_zero_write, watchdog_expired} = 3'h4 >> k;
			cell_count_battery_present = (k != 3);
			adapter_valid_status = (k != 4);
			wt(1);
			{register_reset_cmd, charge_voltage_zero_write, watchdog_expired} = 3'h0;
			wt(12);
			cw({3'h0, charge_current_ma}, 16'h0000);
			cell_count_battery_present = 1'b1;
			adapter_valid_status = 1'b1;
		end
		host.wr(`CMD_OPTION0, 16'hF70E);
		cell_count_battery_present = 1'b0;
		wt(12);
		host.rd(`CMD_OPTION0, r);
		cw(r, 16'hF70C);
		cb(input_regulation_active, 1'b0);
		cell_count_battery_present = 1'b1;
		opt_chk(16'hF70E, 1'b0);
		complete_run();
	end
endmodule
